// >>> logic/sptpio_pkg.sv
/*
 * Constants and types for the serial port timers and receive pin I/O block.
 * Assumes a single 10 MHz core clock and a word-wide plain register port.
 */
package sptpio_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          CLOCK_NS      = 100;

    // Register byte addresses
    localparam logic [7:0]  OFS_PIN_CTL   = 8'h00;
    localparam logic [7:0]  OFS_TIMER_CTL = 8'h04;
    localparam logic [7:0]  OFS_TX_PERIOD = 8'h08;
    localparam logic [7:0]  OFS_RX_PERIOD = 8'h0c;
    localparam logic [7:0]  OFS_TX_COUNT  = 8'h10;
    localparam logic [7:0]  OFS_RX_COUNT  = 8'h14;
    localparam logic [7:0]  OFS_GLOBAL    = 8'h18;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h1c;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h20;

    // Pin control: pin k occupies bits 4k..4k+3 (0 clock, 1 data, 2 sync)
    localparam int          PIN_STRIDE    = 4;
    localparam int          PIN_FUNC      = 0;
    localparam int          PIN_DIR       = 1;
    localparam int          PIN_OUT       = 2;
    localparam int          PIN_IN        = 3;

    // Timer control: timer i occupies bits 6i..6i+5 (0 transmit, 1 receive)
    localparam int          TIM_STRIDE    = 6;
    localparam int          TIM_RESTART   = 0;
    localparam int          TIM_RUN       = 1;
    localparam int          TIM_WAVE      = 2;
    localparam int          TIM_SOURCE    = 3;
    localparam int          TIM_FLAG      = 5;

    // Global control bits kept locally
    localparam int          GLB_RX_CLK_POL = 13;
    localparam int          GLB_TX_IRQ_EN  = 22;
    localparam int          GLB_RX_IRQ_EN  = 24;

    // Reset values
    localparam logic [2:0]  PIN_FIELD_RST = 3'h0;
    localparam logic [31:0] PERIOD_RST    = 32'h0;
    localparam logic [31:0] COUNT_RST     = 32'h0;
    localparam logic [1:0]  IRQ_BITS_RST  = 2'h0;

    localparam int          SYNC_STAGES   = 3;

    typedef struct packed {
        logic run;
        logic wave;
        logic source;
    } sptpio_timer_cfg_t;

    localparam sptpio_timer_cfg_t TIMER_CFG_RST = '{run: 1'b0, wave: 1'b0, source: 1'b0};

endpackage : sptpio_pkg

// >>> logic/sptpio_top.sv
/*
 * Serial port auxiliary logic: transmit and receive timers with interrupt
 * signalling, and the three receive-side pins as serial or general I/O.
 * Assumes the serial core supplies its own pin drives and word interrupts,
 * and that pins and the transmit clock pin are asynchronous to clock.
 */
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps

module sptpio_top
    import sptpio_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic [DATA_W-1:0] writeData,
    input  wire logic              writeStrobe,
    input  wire logic              readStrobe,
    output logic      [DATA_W-1:0] readData,
    input  wire logic [2:0]        pinIn,
    output logic      [2:0]        pinOut,
    output logic      [2:0]        pinOe,
    input  wire logic              transmitClockPinIn,
    input  wire logic [2:0]        serialOut,
    input  wire logic [2:0]        serialOe,
    output logic      [2:0]        serialIn,
    input  wire logic              txWordIrq,
    input  wire logic              rxWordIrq,
    output logic                   txTimerOut,
    output logic                   rxTimerOut,
    output logic                   txCpuIrq,
    output logic                   rxCpuIrq,
    output logic                   irq
);

    function automatic logic [DATA_W-1:0] timerCtlWord(input logic [1:0] goBits,
                                                       input sptpio_timer_cfg_t c0,
                                                       input sptpio_timer_cfg_t c1,
                                                       input logic [1:0] flags);
        logic [DATA_W-1:0] w;
        w = '0;
        w[TIM_RESTART]             = goBits[0];
        w[TIM_RUN]                 = c0.run;
        w[TIM_WAVE]                = c0.wave;
        w[TIM_SOURCE]              = c0.source;
        w[TIM_FLAG]                = flags[0];
        w[TIM_STRIDE+TIM_RESTART]  = goBits[1];
        w[TIM_STRIDE+TIM_RUN]      = c1.run;
        w[TIM_STRIDE+TIM_WAVE]     = c1.wave;
        w[TIM_STRIDE+TIM_SOURCE]   = c1.source;
        w[TIM_STRIDE+TIM_FLAG]     = flags[1];
        return w;
    endfunction : timerCtlWord

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction : hit

    logic [2:0]              pinFunc, pinDir, pinOutVal;
    logic [3:0]              sync1, sync2, sync3, pinStable, pinStablePrev;
    logic [1:0]              go, prescale, irqEnable, irqStatus, irqMask, wrCount;
    logic [1:0]              flag, flagPrev, tick, extRise, periodEnd, flagRise;
    sptpio_timer_cfg_t       cfg [2];
    logic [DATA_W-1:0]       period [2], count [2];
    logic                    rxClkPolarity;
    logic                    wrTimerCtl;
    logic [DATA_W-1:0]       next_readData;

    assign wrTimerCtl = writeStrobe && hit(address, OFS_TIMER_CTL);
    assign wrCount[0] = writeStrobe && hit(address, OFS_TX_COUNT);
    assign wrCount[1] = writeStrobe && hit(address, OFS_RX_COUNT);

    // Pin control register
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            pinFunc   <= PIN_FIELD_RST;
            pinDir    <= PIN_FIELD_RST;
            pinOutVal <= PIN_FIELD_RST;
        end
        else if (writeStrobe && hit(address, OFS_PIN_CTL))
        begin
            for (int k = 0; k < 3; k++)
            begin
                pinFunc[k]   <= writeData[PIN_STRIDE*k+PIN_FUNC];
                pinDir[k]    <= writeData[PIN_STRIDE*k+PIN_DIR];
                pinOutVal[k] <= writeData[PIN_STRIDE*k+PIN_OUT];
            end
        end
    end

    // Three-stage input synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            {sync1, sync2, sync3, pinStable, pinStablePrev} <= '0;
        end
        else
        begin
            sync1         <= {transmitClockPinIn, pinIn};
            sync2         <= sync1;
            sync3         <= sync2;
            pinStable     <= (sync2 ~^ sync3) & sync3 | ~(sync2 ~^ sync3) & pinStable;
            pinStablePrev <= pinStable;
        end
    end

    // Pin drivers: general I/O or serial core
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            {pinOut, pinOe, serialIn} <= '0;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                pinOut[k] <= pinFunc[k] ? serialOut[k] : pinOutVal[k];
                pinOe[k]  <= pinFunc[k] ? serialOe[k] : pinDir[k];
            end
            serialIn <= pinStable[2:0];
        end
    end

    // Global enables and polarity
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            irqEnable     <= IRQ_BITS_RST;
            rxClkPolarity <= 1'b0;
        end
        else if (writeStrobe && hit(address, OFS_GLOBAL))
        begin
            irqEnable     <= {writeData[GLB_RX_IRQ_EN], writeData[GLB_TX_IRQ_EN]};
            rxClkPolarity <= writeData[GLB_RX_CLK_POL];
        end
    end

    // Timer clock ticks; internal source is half the core clock
    assign extRise[0] = pinStable[3] & ~pinStablePrev[3];
    assign extRise[1] = pinStable[0] & ~pinStablePrev[0];

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            tick[i]      = cfg[i].run && (cfg[i].source ? prescale[i] : extRise[i]);
            periodEnd[i] = tick[i] && !go[i] && (count[i] == period[i]);
        end
    end

    // Timer control bits
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            go     <= '0;
            cfg[0] <= TIMER_CFG_RST;
            cfg[1] <= TIMER_CFG_RST;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                // A fresh write of one beats the self-clear
                if (wrTimerCtl && writeData[TIM_STRIDE*i+TIM_RESTART])
                    go[i] <= 1'b1;
                else if (tick[i] && go[i])
                    go[i] <= 1'b0;
                if (wrTimerCtl)
                begin
                    cfg[i].run    <= writeData[TIM_STRIDE*i+TIM_RUN];
                    cfg[i].wave   <= writeData[TIM_STRIDE*i+TIM_WAVE];
                    cfg[i].source <= writeData[TIM_STRIDE*i+TIM_SOURCE];
                end
            end
        end
    end

    // Period registers
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            period[0] <= PERIOD_RST;
            period[1] <= PERIOD_RST;
        end
        else
        begin
            if (writeStrobe && hit(address, OFS_TX_PERIOD))
                period[0] <= writeData;
            if (writeStrobe && hit(address, OFS_RX_PERIOD))
                period[1] <= writeData;
        end
    end

    // Counters and prescalers; both stand still while held
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            count[0] <= COUNT_RST;
            count[1] <= COUNT_RST;
            prescale <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (cfg[i].run && cfg[i].source)
                    prescale[i] <= ~prescale[i];
                if (wrCount[i])
                    count[i] <= writeData;
                else if (tick[i] && (go[i] || periodEnd[i]))
                    count[i] <= COUNT_RST;
                else if (tick[i])
                    count[i] <= count[i] + 32'h1;
            end
        end
    end

    // Status flags and timer outputs
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            {flag, flagPrev, txTimerOut, rxTimerOut} <= '0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (cfg[i].wave)
                    flag[i] <= flag[i] ^ periodEnd[i];
                else
                    flag[i] <= periodEnd[i];
            end
            flagPrev   <= flag;
            txTimerOut <= cfg[0].wave ? flag[0] ^ periodEnd[0] : periodEnd[0];
            // Pin level may be inverted; the status flag never is
            rxTimerOut <= (cfg[1].wave ? flag[1] ^ periodEnd[1] : periodEnd[1]) ^ rxClkPolarity;
        end
    end

    assign flagRise = flag & ~flagPrev;

    // Interrupt status, mask and request lines
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            irqStatus <= IRQ_BITS_RST;
            irqMask   <= IRQ_BITS_RST;
            {txCpuIrq, rxCpuIrq, irq} <= '0;
        end
        else
        begin
            if (writeStrobe && hit(address, OFS_IRQ_MASK))
                irqMask <= writeData[1:0];
            // Set wins over a write-one clear in the same cycle
            if (writeStrobe && hit(address, OFS_IRQ_STAT))
                irqStatus <= (irqStatus & ~writeData[1:0]) | flagRise;
            else
                irqStatus <= irqStatus | flagRise;
            txCpuIrq <= (flagRise[0] && irqEnable[0]) || txWordIrq;
            rxCpuIrq <= (flagRise[1] && irqEnable[1]) || rxWordIrq;
            irq      <= |(irqStatus & irqMask);
        end
    end

    // Read mux; data stand one cycle after the strobe
    always_comb
    begin
        next_readData = '0;
        if (readStrobe)
        begin
            case (address)
                OFS_PIN_CTL:
                begin
                    for (int k = 0; k < 3; k++)
                    begin
                        next_readData[PIN_STRIDE*k+PIN_FUNC] = pinFunc[k];
                        next_readData[PIN_STRIDE*k+PIN_DIR]  = pinDir[k];
                        next_readData[PIN_STRIDE*k+PIN_OUT]  = pinOutVal[k];
                        next_readData[PIN_STRIDE*k+PIN_IN]   = pinStable[k];
                    end
                end
                OFS_TIMER_CTL: next_readData = timerCtlWord(go, cfg[0], cfg[1], flag);
                OFS_TX_PERIOD: next_readData = period[0];
                OFS_RX_PERIOD: next_readData = period[1];
                OFS_TX_COUNT:  next_readData = count[0];
                OFS_RX_COUNT:  next_readData = count[1];
                OFS_GLOBAL:
                begin
                    next_readData[GLB_TX_IRQ_EN]  = irqEnable[0];
                    next_readData[GLB_RX_IRQ_EN]  = irqEnable[1];
                    next_readData[GLB_RX_CLK_POL] = rxClkPolarity;
                end
                OFS_IRQ_STAT:  next_readData[1:0] = irqStatus;
                OFS_IRQ_MASK:  next_readData[1:0] = irqMask;
                default:       next_readData = '0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            readData <= '0;
        else
            readData <= next_readData;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence restartTakenSeq(int i);
        go[i] && tick[i] && !wrTimerCtl && !wrCount[i];
    endsequence

    sequence counterClearedSeq(int i);
        count[i] == 32'h0 && !go[i];
    endsequence

    gpio_output_drive_a: assert property (!pinFunc[0] |=> pinOe[0] == $past(pinDir[0]))
        else $error("general pin enable does not follow direction bit");
    serial_pin_pass_a: assert property (pinFunc[1] |=> pinOut[1] == $past(serialOut[1])
                                        && pinOe[1] == $past(serialOe[1]))
        else $error("serial pin not driven by serial core");
    gpio_out_value_a: assert property (!pinFunc[2] && pinDir[2] |=> pinOut[2] == $past(pinOutVal[2]))
        else $error("general output does not show out value");
    restart_clear_a: assert property (restartTakenSeq(0) |=> counterClearedSeq(0))
        else $error("restart did not zero counter and clear go");
    hold_freeze_a: assert property (!cfg[1].run && !wrCount[1] |=> $stable(count[1]) && $stable(prescale[1]))
        else $error("held timer changed state");
    pulse_one_cycle_a: assert property (!cfg[0].wave && flag[0] && !$past(cfg[0].wave) |=> !flag[0])
        else $error("pulse mode flag high longer than one cycle");
    irq_on_rise_a: assert property ($rose(flag[1]) && irqEnable[1] |=> rxCpuIrq)
        else $error("flag rise did not raise receive irq");
    irq_gated_a: assert property (txCpuIrq |-> $past(irqEnable[0] && flagRise[0]) || $past(txWordIrq))
        else $error("transmit irq without enabled cause");

endmodule : sptpio_top

// >>> verif/sptpio_far_side.sv
/*
 * Far side of the receive pins and timer clock inputs: pin devices and
 * two external clock sources. Assumes the bench sets farLevel and clkRun.
 */
`timescale 1ns/10ps
module sptpio_far_side
    import sptpio_pkg::*;
(
    input  wire logic [2:0] pinOut,
    input  wire logic [2:0] pinOe,
    input  wire logic [2:0] farLevel,
    input  wire logic [1:0] clkRun,
    output logic      [2:0] pinIn,
    output logic            transmitClockPinIn,
    output int              edges
);
    // 740 ns period stays under the limit and drifts against the core clock
    localparam int HALF_NS = 370;

    logic txClk = 1'b0;
    logic rxClk = 1'b0;

    initial
        edges = 0;

    // A stopped source finishes its high phase, then stands low
    always #HALF_NS
    begin
        if (clkRun[0] || txClk)
            txClk = ~txClk;
        if (clkRun[1] || rxClk)
            rxClk = ~rxClk;
        edges = edges + int'(clkRun[0] && txClk) + int'(clkRun[1] && rxClk);
    end

    assign transmitClockPinIn = txClk;
    // Design drive wins where enabled; far devices drive the rest
    assign pinIn[0]   = pinOe[0] ? pinOut[0] : (farLevel[0] | rxClk);
    assign pinIn[2:1] = (pinOe[2:1] & pinOut[2:1]) | (~pinOe[2:1] & farLevel[2:1]);
endmodule : sptpio_far_side

// >>> verif/tb_sptpio_top.sv
/*
 * Self-checking bench for the serial port timers and receive pin I/O.
 * Assumes the far-side model resolves pins and makes external clocks.
 */
`timescale 1ns/10ps
module tb_sptpio_top
    import sptpio_pkg::*;
;
    logic              clock;
    logic              reset;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writeData;
    logic              writeStrobe;
    logic              readStrobe;
    logic [DATA_W-1:0] readData;
    logic [2:0]        pinIn;
    logic [2:0]        pinOut;
    logic [2:0]        pinOe;
    logic              transmitClockPinIn;
    logic [2:0]        serialOut;
    logic [2:0]        serialOe;
    logic [2:0]        serialIn;
    logic              txWordIrq;
    logic              rxWordIrq;
    logic              txTimerOut;
    logic              rxTimerOut;
    logic              txCpuIrq;
    logic              rxCpuIrq;
    logic              irq;
    logic [2:0]        farLevel;
    logic [1:0]        clkRun;
    int                edges;
    int                failures;
    int                checksDone;

    sptpio_top u_sptpio_top (.clock(clock), .reset(reset), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .transmitClockPinIn(transmitClockPinIn), .serialOut(serialOut),
        .serialOe(serialOe), .serialIn(serialIn), .txWordIrq(txWordIrq), .rxWordIrq(rxWordIrq),
        .txTimerOut(txTimerOut), .rxTimerOut(rxTimerOut), .txCpuIrq(txCpuIrq), .rxCpuIrq(rxCpuIrq),
        .irq(irq));

    sptpio_far_side u_sptpio_far_side (.pinOut(pinOut), .pinOe(pinOe), .farLevel(farLevel),
        .clkRun(clkRun), .pinIn(pinIn), .transmitClockPinIn(transmitClockPinIn), .edges(edges));

    initial
    begin
        clock = 1'b0;
        forever #(CLOCK_NS / 2) clock = ~clock;
    end

    function automatic logic pick(input int t, input logic a, input logic b);
        return t ? b : a;
    endfunction : pick

    task automatic close_out;
        if (failures == 0 && checksDone > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checksDone++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc

    task automatic do_reset;
        reset <= 1'b1;
        cyc(4);
        reset <= 1'b0;
        @(posedge clock);
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        address     <= a;
        writeData   <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        address    <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 d = readData;
        @(posedge clock);
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp, "register read");
    endtask : rdchk

    // Bounded wait for a rise, then high time and rise-to-rise spacing
    task automatic meas(input int t, output int hi, output int per);
        int n;
        n = 0;
        hi = 0;
        @(negedge clock);
        while (pick(t, txTimerOut, rxTimerOut) !== 1'b1 && n < 100)
        begin
            @(negedge clock);
            n++;
        end
        while (pick(t, txTimerOut, rxTimerOut) === 1'b1 && hi < 100)
        begin
            @(negedge clock);
            hi++;
        end
        per = hi;
        while (pick(t, txTimerOut, rxTimerOut) !== 1'b1 && per < 100)
        begin
            @(negedge clock);
            per++;
        end
        @(posedge clock);
    endtask : meas

    task automatic watch(input int t, output logic s);
        s = 1'b0;
        repeat (20)
        begin
            @(negedge clock);
            s = s | pick(t, txCpuIrq, rxCpuIrq);
        end
        @(posedge clock);
    endtask : watch

    task automatic t_regs;
        do_reset;
        for (int i = 0; i < 9; i++)
            rdchk(8'(4 * i), 32'h0);
        wr(8'h40, 32'hffffffff);
        rdchk(8'h40, 32'h0);
        rdchk(OFS_PIN_CTL, 32'h0);
        wr(OFS_TIMER_CTL, 32'h820);
        rdchk(OFS_TIMER_CTL, 32'h0);
        wr(OFS_GLOBAL, 32'h2000);
        cyc(1);
        @(negedge clock);
        chk({rxTimerOut, txTimerOut}, 32'h2, "polarity");
        @(posedge clock);
        rdchk(OFS_TIMER_CTL, 32'h0);
    endtask : t_regs

    task automatic t_wave(input int t, input logic wave);
        int hi;
        int per;
        do_reset;
        wr(8'(OFS_TX_PERIOD + 4 * t), 32'h2);
        wr(OFS_TIMER_CTL, (32'h0b | (32'(wave) << 2)) << (6 * t));
        meas(t, hi, per);
        chk(32'(hi), wave ? 32'h6 : 32'h1, "high time");
        chk(32'(per), wave ? 32'hc : 32'h6, "period");
        rdchk(OFS_TIMER_CTL, (wave ? 32'h2e : 32'h0a) << (6 * t));
    endtask : t_wave

    task automatic t_irq(input int t);
        logic s;
        do_reset;
        wr(OFS_GLOBAL, t ? 32'h01000000 : 32'h00400000);
        wr(8'(OFS_TX_PERIOD + 4 * t), 32'h2);
        wr(OFS_TIMER_CTL, 32'h0b << (6 * t));
        watch(t, s);
        chk(32'(s), 32'h1, "timer irq");
        rdchk(OFS_IRQ_STAT, 32'(1 << t));
        @(negedge clock);
        chk(32'(irq), 32'h0, "masked irq");
        @(posedge clock);
        wr(OFS_IRQ_MASK, 32'(1 << t));
        cyc(1);
        @(negedge clock);
        chk(32'(irq), 32'h1, "unmasked irq");
        @(posedge clock);
        wr(OFS_TIMER_CTL, 32'h0);
        wr(OFS_IRQ_STAT, 32'(1 << t));
        cyc(1);
        @(negedge clock);
        chk(32'(irq), 32'h0, "cleared irq");
        @(posedge clock);
        rdchk(OFS_IRQ_STAT, 32'h0);
        wr(OFS_GLOBAL, 32'h0);
        wr(OFS_TIMER_CTL, 32'h0b << (6 * t));
        watch(t, s);
        chk(32'(s), 32'h0, "disabled irq");
        {rxWordIrq, txWordIrq} <= 2'(1 << t);
        cyc(2);
        @(negedge clock);
        chk(32'(pick(t, txCpuIrq, rxCpuIrq)), 32'h1, "word irq");
        @(posedge clock);
        {rxWordIrq, txWordIrq} <= 2'b00;
    endtask : t_irq

    task automatic t_ext(input int t);
        int e0;
        logic [31:0] v;
        do_reset;
        wr(8'(OFS_TX_PERIOD + 4 * t), 32'h3e8);
        wr(OFS_TIMER_CTL, 32'h03 << (6 * t));
        e0 = edges;
        clkRun <= 2'(1 << t);
        cyc(150);
        clkRun <= 2'b00;
        cyc(12);
        rd(8'(OFS_TX_COUNT + 4 * t), v);
        chk(v, 32'(edges - e0 - 1), "external count");
    endtask : t_ext

    task automatic t_hold;
        logic [31:0] a;
        logic [31:0] b;
        do_reset;
        wr(OFS_TX_PERIOD, 32'h64);
        wr(OFS_TIMER_CTL, 32'h0b);
        cyc(20);
        wr(OFS_TIMER_CTL, 32'h0a);
        rdchk(OFS_TIMER_CTL, 32'h0a);
        rd(OFS_TX_COUNT, a);
        chk(32'(a >= 10), 32'h1, "count kept");
        wr(OFS_TIMER_CTL, 32'h08);
        rd(OFS_TX_COUNT, a);
        cyc(10);
        rdchk(OFS_TX_COUNT, a);
        wr(OFS_TX_COUNT, 32'h7);
        rdchk(OFS_TX_COUNT, 32'h7);
        wr(OFS_TIMER_CTL, 32'h0a);
        cyc(8);
        rd(OFS_TX_COUNT, b);
        chk(32'(b >= 10 && b <= 13), 32'h1, "resumed count");
        wr(OFS_TIMER_CTL, 32'h08);
        do_reset;
        rdchk(OFS_TX_COUNT, 32'h0);
        rdchk(OFS_TIMER_CTL, 32'h0);
    endtask : t_hold

    task automatic t_pins;
        do_reset;
        farLevel <= 3'b101;
        wr(OFS_PIN_CTL, 32'h666);
        cyc(1);
        @(negedge clock);
        chk({pinOe, pinOut}, 32'h3f, "output high");
        @(posedge clock);
        cyc(4);
        rdchk(OFS_PIN_CTL, 32'heee);
        wr(OFS_PIN_CTL, 32'h222);
        cyc(1);
        @(negedge clock);
        chk({pinOe, pinOut}, 32'h38, "output low");
        @(posedge clock);
        wr(OFS_PIN_CTL, 32'h888);
        cyc(5);
        rdchk(OFS_PIN_CTL, 32'h808);
        serialOe  <= 3'b011;
        serialOut <= 3'b010;
        wr(OFS_PIN_CTL, 32'h111);
        cyc(5);
        @(negedge clock);
        chk({pinOe, pinOut[1:0], serialIn}, 32'h76, "serial pins");
        @(posedge clock);
    endtask : t_pins

    initial
    begin
        #(CLOCK_NS * 20000);
        failures++;
        close_out;
    end

    initial
    begin
        reset       = 1'b1;
        address     = '0;
        writeData   = '0;
        writeStrobe = 1'b0;
        readStrobe  = 1'b0;
        serialOut   = 3'b000;
        serialOe    = 3'b000;
        txWordIrq   = 1'b0;
        rxWordIrq   = 1'b0;
        farLevel    = 3'b000;
        clkRun      = 2'b00;
        failures    = 0;
        checksDone  = 0;
        cyc(4);
        reset <= 1'b0;
        @(posedge clock);
        t_regs;
        for (int t = 0; t < 2; t++)
        begin
            t_wave(t, 1'b0);
            t_wave(t, 1'b1);
            t_irq(t);
            t_ext(t);
        end
        t_hold;
        t_pins;
        close_out;
    end
endmodule : tb_sptpio_top
